// ### hw/egh_top.sv
module egh_top (
	input  wire logic                      ref_clk,        // control clock
	input  wire logic                      rst_n,          // async reset, low
	input  wire logic [7:0]                paddr,          // apb address
	input  wire logic                      psel,           // apb select
	input  wire logic                      penable,        // apb enable
	input  wire logic                      pwrite,         // apb direction
	input  wire logic [31:0]               pwdata,         // apb write data
	output logic      [31:0]               prdata,         // apb read data
	output logic                           pready,         // apb ready
	output logic                           pslverr,        // apb error
	input  wire logic                      cmd_valid,      // command pulse strobe
	input  wire logic signed [15:0]        cmd_delta,      // command pulses
	input  wire logic                      trig_in,        // homing trigger
	input  wire logic                      motion_stopped, // motion stage at rest
	output logic                           enc_valid,      // scaled strobe
	output logic signed [31:0]             enc_delta,      // scaled counts
	output logic [egh_pkg::VEL_W-1:0]      prof_vel,       // profile target speed
	output logic [egh_pkg::ACC_W-1:0]      prof_rate,      // accel or decel rate
	output logic                           prof_dir,       // homing direction
	output logic                           pos_zero,       // set position zero
	output logic                           mt_clear,       // multi-turn clear
	output logic                           speed_unit,     // speed unit select
	output logic                           irq             // interrupt, high
);
	import egh_pkg::*;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	egh_gear_if gif ();

	logic [CTRL_W-1:0] ctrl_q;
	logic [31:0]       ppr_q;
	logic [31:0]       num_q;
	logic [31:0]       den_q;
	logic [ACC_W-1:0]  acc_q;
	logic [ACC_W-1:0]  dec_q;
	logic [VEL_W-1:0]  vfast_q;
	logic [VEL_W-1:0]  vslow_q;
	logic [7:0]        code_q;
	logic [7:0]        type_q;
	logic [IRQ_W-1:0]  ist_q;
	logic [IRQ_W-1:0]  ist_d;
	logic [IRQ_W-1:0]  imask_q;
	logic [31:0]       rdata;
	logic              hit;
	logic              setup;
	logic              wr;
	logic              wr_cmd;
	logic [7:0]        new_code;
	logic [7:0]        new_type;
	logic              is_home;
	logic              start;
	logic              reject;
	logic              mt_req;
	logic              trig_q;
	logic              trig_edge;
	logic              pready_q;
	logic [31:0]       prdata_q;
	logic              pslverr_q;
	logic              irq_q;
	logic              mt_clear_q;
	logic              pos_zero_q;
	logic              done_q;
	logic              inprog_q;
	logic              dir_q;
	logic [VEL_W-1:0]  vel_q;
	logic [ACC_W-1:0]  rate_q;
	egh_mode_t         mode;
	egh_hstate_t       state_q;

	function automatic logic [ACC_W-1:0] acc_clamp(input logic [31:0] v);
		logic [ACC_W-1:0] r;
		r = v[ACC_W-1:0];
		if (v < ACC_MIN) begin
			r = ACC_MIN[ACC_W-1:0];
		end else if (v > ACC_MAX) begin
			r = ACC_MAX[ACC_W-1:0];
		end
		return r;
	endfunction

	egh_gear u_gear (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.gp      (gif.gear)
	);

	assign gif.ppr = ppr_q;
	assign gif.num = num_q;
	assign gif.den = den_q;
	assign gif.in_valid = cmd_valid;
	assign gif.in_delta = cmd_delta;

	// apb decode
	assign setup = psel && !penable;
	assign wr = psel && penable && pready_q && pwrite;
	assign wr_cmd = wr && (paddr == OFS_CMD);
	assign mode = egh_mode_t'(ctrl_q[CTRL_MODE +: 2]);
	assign new_code = pwdata[7:0];
	assign new_type = pwdata[15:8];
	assign is_home = (new_code == CMD_HOME)
		&& ((new_type == TYPE_HOME_Z) || (new_type == TYPE_HOME_H));
	// launch only from a held normal command with same type
	assign start = wr_cmd && is_home && (mode == MODE_PP) && (state_q == H_IDLE)
		&& (code_q == CMD_NORMAL) && (type_q == new_type);
	assign reject = wr_cmd && is_home && !start;
	assign mt_req = wr_cmd && (new_code == CMD_HOME) && (new_type == TYPE_MT_CLR);
	assign trig_edge = ctrl_q[CTRL_POL] ? (trig_q && !trig_in) : (!trig_q && trig_in);

	always_comb begin
		rdata = 32'h0;
		hit = 1'b1;
		case (paddr)
			OFS_CTRL: rdata[CTRL_W-1:0] = ctrl_q;
			OFS_PPR: rdata = ppr_q;
			OFS_NUM: rdata = num_q;
			OFS_DEN: rdata = den_q;
			OFS_ACC: rdata[ACC_W-1:0] = acc_q;
			OFS_DEC: rdata[ACC_W-1:0] = dec_q;
			OFS_VFAST: rdata[VEL_W-1:0] = vfast_q;
			OFS_VSLOW: rdata[VEL_W-1:0] = vslow_q;
			OFS_CMD: rdata[15:0] = {type_q, code_q};
			OFS_STAT: begin
				rdata[15:0] = {type_q, code_q};
				rdata[ST_INPROG] = inprog_q;
				rdata[ST_DONE] = done_q;
				rdata[ST_STATE +: 3] = state_q;
			end
			OFS_IST: rdata[IRQ_W-1:0] = ist_q;
			OFS_IMASK: rdata[IRQ_W-1:0] = imask_q;
			default: hit = 1'b0;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pready_q <= 1'b0;
			prdata_q <= 32'h0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= setup;
			pslverr_q <= setup && !hit;
			if (setup) begin
				prdata_q <= rdata;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= '0;
			ppr_q <= 32'h0;
			num_q <= NUM_RST;
			den_q <= DEN_RST;
			acc_q <= ACC_MIN[ACC_W-1:0];
			dec_q <= ACC_MIN[ACC_W-1:0];
			vfast_q <= '0;
			vslow_q <= '0;
			imask_q <= '0;
		end else if (wr) begin
			case (paddr)
				OFS_CTRL: ctrl_q <= pwdata[CTRL_W-1:0];
				OFS_PPR: ppr_q <= pwdata;
				OFS_NUM: num_q <= pwdata;
				OFS_DEN: den_q <= pwdata;
				OFS_ACC: acc_q <= acc_clamp(pwdata);
				OFS_DEC: dec_q <= acc_clamp(pwdata);
				OFS_VFAST: vfast_q <= pwdata[VEL_W-1:0];
				OFS_VSLOW: vslow_q <= pwdata[VEL_W-1:0];
				OFS_IMASK: imask_q <= pwdata[IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	// command echo holds the last written code and type
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			code_q <= 8'h0;
			type_q <= 8'h0;
			mt_clear_q <= 1'b0;
		end else begin
			mt_clear_q <= mt_req;
			if (wr_cmd) begin
				code_q <= new_code;
				type_q <= new_type;
			end
		end
	end

	// sticky events, set wins over write-one clear
	always_comb begin
		ist_d = ist_q;
		if (wr && paddr == OFS_IST) begin
			ist_d = ist_d & ~pwdata[IRQ_W-1:0];
		end
		ist_d[IRQ_MULT] = ist_d[IRQ_MULT] | gif.mult_err;
		ist_d[IRQ_HOMED] = ist_d[IRQ_HOMED] | (state_q == H_ZERO);
		ist_d[IRQ_CMDERR] = ist_d[IRQ_CMDERR] | reject;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ist_q <= '0;
			irq_q <= 1'b0;
		end else begin
			ist_q <= ist_d;
			irq_q <= |(ist_d & imask_q);
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			trig_q <= 1'b0;
		end else begin
			trig_q <= trig_in;
		end
	end

	// profile homing sequencer
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= H_IDLE;
			vel_q <= '0;
			rate_q <= ACC_MIN[ACC_W-1:0];
			dir_q <= 1'b0;
			pos_zero_q <= 1'b0;
			done_q <= 1'b0;
			inprog_q <= 1'b0;
		end else begin
			pos_zero_q <= 1'b0;
			case (state_q)
				H_IDLE: begin
					if (start) begin
						state_q <= H_FAST;
						done_q <= 1'b0;
						inprog_q <= 1'b1;
						dir_q <= ctrl_q[CTRL_POL];
					end
				end
				H_FAST: begin
					vel_q <= vfast_q;
					rate_q <= acc_q;
					if (trig_edge) begin
						state_q <= H_BRAKE;
					end
				end
				H_BRAKE: begin
					vel_q <= '0;
					rate_q <= dec_q;
					if (motion_stopped) begin
						state_q <= H_SLOW;
					end
				end
				H_SLOW: begin
					vel_q <= vslow_q;
					rate_q <= acc_q;
					if (trig_edge) begin
						state_q <= H_STOP;
					end
				end
				H_STOP: begin
					vel_q <= '0;
					rate_q <= dec_q;
					if (motion_stopped) begin
						state_q <= H_ZERO;
						pos_zero_q <= 1'b1;
					end
				end
				H_ZERO: begin
					done_q <= 1'b1;
					inprog_q <= 1'b0;
					state_q <= H_IDLE;
				end
				default: state_q <= H_IDLE;
			endcase
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign enc_valid = gif.out_valid;
	assign enc_delta = gif.out_delta;
	assign prof_vel = vel_q;
	assign prof_rate = rate_q;
	assign prof_dir = dir_q;
	assign pos_zero = pos_zero_q;
	assign mt_clear = mt_clear_q;
	assign speed_unit = ctrl_q[CTRL_UNIT];
	assign irq = irq_q;

	sequence s_start;
		start;
	endsequence
	sequence s_running;
		inprog_q && !done_q && state_q == H_FAST;
	endsequence
	property p_start;
		s_start |=> s_running;
	endproperty
	a_start: assert property (p_start) else $error("homing did not start");

	property p_reject;
		(wr_cmd && is_home && (mode == MODE_CV || mode == MODE_CT)) |=>
			ist_q[IRQ_CMDERR] && state_q == H_IDLE;
	endproperty
	a_reject: assert property (p_reject) else $error("homing not rejected");

	property p_fast_vel;
		(state_q == H_FAST) |=> (vel_q == $past(vfast_q)) && (rate_q == $past(acc_q));
	endproperty
	a_fast_vel: assert property (p_fast_vel) else $error("fast phase speed wrong");

	property p_slow_vel;
		(state_q == H_SLOW) |=> (vel_q == $past(vslow_q));
	endproperty
	a_slow_vel: assert property (p_slow_vel) else $error("slow phase speed wrong");

	property p_decel;
		(state_q == H_BRAKE || state_q == H_STOP) |=> (rate_q == $past(dec_q)) && (vel_q == '0);
	endproperty
	a_decel: assert property (p_decel) else $error("stop not at decel rate");

	property p_done_after_zero;
		$rose(done_q) |-> $past(pos_zero_q) && !inprog_q;
	endproperty
	a_done_after_zero: assert property (p_done_after_zero) else $error("done before zero");

	property p_edge;
		(state_q == H_FAST && trig_edge) |=> state_q == H_BRAKE;
	endproperty
	a_edge: assert property (p_edge) else $error("trigger edge missed");

	property p_echo;
		wr_cmd |=> ({type_q, code_q} == $past(pwdata[15:0]));
	endproperty
	a_echo: assert property (p_echo) else $error("command echo wrong");

	property p_acc_range;
		(acc_q >= ACC_MIN[ACC_W-1:0]) && (acc_q <= ACC_MAX[ACC_W-1:0]);
	endproperty
	a_acc_range: assert property (p_acc_range) else $error("accel out of range");
endmodule

// ### shared/egh_pkg.sv
// Notes on behaviour
// - nonzero ppr: ratio is 2^23 over ppr
// - ppr zero: ratio is numerator over denominator
// - out-of-bounds scaled command raises multiplication alarm
// - profile position homing runs autonomously once requested
// - no homing in velocity/torque modes, except multi-turn clear
// - profile acceleration 1..429496, set before profile start
// - profile deceleration 1..429496 for all stops
// - polarity bit selects homing trigger edge/direction
// - fast homing velocity drives high-speed phases
// - slow homing velocity drives final approach
// - speed unit bit applies to commands and responses
// - complete flag cleared at start, set after zeroing
// - echo command and type, show in-progress status
package egh_pkg;
	localparam logic [31:0] ENC_RES = 32'h0080_0000;
	localparam logic signed [63:0] GEAR_OUT_MAX = 64'sh0000_0000_7fff_ffff;
	localparam logic [7:0] CMD_NORMAL = 8'h10;
	localparam logic [7:0] CMD_HOME = 8'h17;
	localparam logic [7:0] TYPE_HOME_Z = 8'h31;
	localparam logic [7:0] TYPE_HOME_H = 8'h32;
	localparam logic [7:0] TYPE_MT_CLR = 8'h50;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_PPR = 8'h04;
	localparam logic [7:0] OFS_NUM = 8'h08;
	localparam logic [7:0] OFS_DEN = 8'h0c;
	localparam logic [7:0] OFS_ACC = 8'h10;
	localparam logic [7:0] OFS_DEC = 8'h14;
	localparam logic [7:0] OFS_VFAST = 8'h18;
	localparam logic [7:0] OFS_VSLOW = 8'h1c;
	localparam logic [7:0] OFS_CMD = 8'h20;
	localparam logic [7:0] OFS_STAT = 8'h24;
	localparam logic [7:0] OFS_IST = 8'h28;
	localparam logic [7:0] OFS_IMASK = 8'h2c;
	localparam int unsigned CTRL_MODE = 0;
	localparam int unsigned CTRL_UNIT = 2;
	localparam int unsigned CTRL_POL = 3;
	localparam int unsigned CTRL_W = 4;
	localparam int unsigned ST_INPROG = 16;
	localparam int unsigned ST_DONE = 17;
	localparam int unsigned ST_STATE = 20;
	localparam int unsigned IRQ_MULT = 0;
	localparam int unsigned IRQ_HOMED = 1;
	localparam int unsigned IRQ_CMDERR = 2;
	localparam int unsigned IRQ_W = 3;
	localparam int unsigned ACC_W = 19;
	localparam int unsigned VEL_W = 31;
	localparam logic [31:0] ACC_MIN = 32'h0000_0001;
	localparam logic [31:0] ACC_MAX = 32'h0006_8db8;
	localparam logic [31:0] NUM_RST = 32'h0000_0001;
	localparam logic [31:0] DEN_RST = 32'h0000_0001;
	typedef enum logic [1:0] {
		MODE_CP = 2'b00,
		MODE_PP = 2'b01,
		MODE_CV = 2'b10,
		MODE_CT = 2'b11
	} egh_mode_t;
	typedef enum logic [2:0] {
		H_IDLE  = 3'b000,
		H_FAST  = 3'b001,
		H_BRAKE = 3'b010,
		H_SLOW  = 3'b011,
		H_STOP  = 3'b100,
		H_ZERO  = 3'b101
	} egh_hstate_t;
endpackage

// ### shared/egh_gear_if.sv
interface egh_gear_if;
	logic [31:0]        ppr;
	logic [31:0]        num;
	logic [31:0]        den;
	logic               in_valid;
	logic signed [15:0] in_delta;
	logic               out_valid;
	logic signed [31:0] out_delta;
	logic               mult_err;
	modport main (output ppr, num, den, in_valid, in_delta, input out_valid, out_delta, mult_err);
	modport gear (input ppr, num, den, in_valid, in_delta, output out_valid, out_delta, mult_err);
endinterface

// ### hw/egh_gear.sv
module egh_gear (
	input wire logic ref_clk, // control clock
	input wire logic rst_n,   // async reset, low
	egh_gear_if.gear gp       // gear request and answer
);
	import egh_pkg::*;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	logic signed [63:0] rem_q;
	logic signed [63:0] rem_d;
	logic signed [63:0] prod;
	logic signed [63:0] quo;
	logic signed [63:0] deno_s;
	logic [31:0]        nume;
	logic [31:0]        deno;
	logic               ovf;
	logic               valid_q;
	logic signed [31:0] delta_q;
	logic               err_q;

	always_comb begin
		nume = (gp.ppr != 32'h0) ? ENC_RES : gp.num;
		deno = (gp.ppr != 32'h0) ? gp.ppr : gp.den;
		deno_s = $signed({32'h0, deno});
		prod = $signed({{48{gp.in_delta[15]}}, gp.in_delta}) * $signed({32'h0, nume}) + rem_q;
		quo = 64'sh0;
		rem_d = rem_q;
		if (deno != 32'h0) begin
			quo = prod / deno_s;
			rem_d = prod % deno_s;
		end
		ovf = (deno == 32'h0) || (quo > GEAR_OUT_MAX) || (quo < -GEAR_OUT_MAX);
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rem_q <= 64'sh0;
		end else if (gp.in_valid && !ovf) begin
			rem_q <= rem_d;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			valid_q <= 1'b0;
			delta_q <= 32'sh0;
			err_q <= 1'b0;
		end else begin
			valid_q <= gp.in_valid && !ovf;
			err_q <= gp.in_valid && ovf;
			if (gp.in_valid && !ovf) begin
				delta_q <= quo[31:0];
			end
		end
	end

	assign gp.out_valid = valid_q;
	assign gp.out_delta = delta_q;
	assign gp.mult_err = err_q;

	property p_gear_answer;
		gp.in_valid |=> (gp.out_valid ^ gp.mult_err);
	endproperty
	a_gear_answer: assert property (p_gear_answer) else $error("gear gave no single answer");

	// quotient times ppr plus new remainder gives back input times 2^23 plus old remainder
	property p_ppr_scale;
		(gp.in_valid && gp.ppr != 32'h0 && !ovf) |=>
			(($signed({{32{gp.out_delta[31]}}, gp.out_delta})
				* $signed({32'h0, $past(gp.ppr)}) + rem_q)
			== $past($signed({{48{gp.in_delta[15]}}, gp.in_delta})
				* $signed({32'h0, ENC_RES}) + rem_q));
	endproperty
	a_ppr_scale: assert property (p_ppr_scale) else $error("ppr scaling wrong");

	// a ratio change may leave an old remainder above the new divisor, so check after updates
	property p_rem_bound;
		(gp.in_valid && !ovf) |=> (rem_q < $past(deno_s)) && (rem_q > -$past(deno_s));
	endproperty
	a_rem_bound: assert property (p_rem_bound) else $error("remainder out of range");
endmodule

// ### verif/egh_host.sv
module egh_host (
	input  wire logic        ref_clk, // control clock
	output logic      [7:0]  paddr,   // apb address
	output logic             psel,    // apb select
	output logic             penable, // apb enable
	output logic             pwrite,  // apb direction
	output logic      [31:0] pwdata,  // apb write data
	input  wire logic [31:0] prdata,  // apb read data
	input  wire logic        pready,  // apb ready
	input  wire logic        pslverr  // apb error
);
	timeunit 1ns;
	timeprecision 100ps;
	import egh_pkg::*;

	initial begin
		paddr = 8'h00;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		pwdata = 32'h0;
	end

	// request held until pready is seen at an edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		@(posedge ref_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) tb_electronic_gear_and_homing_setup.give_up();
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic e);
		apb(1'b0, a, 32'h0, q, e);
	endtask

	// homing before any positioning, launched as normal then home code
	task automatic home(input logic [7:0] typ, input logic ok);
		logic [31:0] q;
		logic        e;
		wr(OFS_CMD, {16'h0, typ, CMD_NORMAL});
		wr(OFS_CMD, {16'h0, typ, CMD_HOME});
		rd(OFS_STAT, q, e);
		tb_electronic_gear_and_homing_setup.chk("echo", {typ, CMD_HOME}, q[15:0]);
		tb_electronic_gear_and_homing_setup.chk("busy", ok, q[ST_INPROG]);
		tb_electronic_gear_and_homing_setup.chk("done", 1'b0, q[ST_DONE]);
	endtask
endmodule

// ### verif/tb_electronic_gear_and_homing_setup.sv
module tb_electronic_gear_and_homing_setup;
	timeunit 1ns;
	timeprecision 100ps;
	import egh_pkg::*;

	typedef struct {
		logic               cfg;
		logic [31:0]        ppr;
		logic [31:0]        num;
		logic [31:0]        den;
		logic signed [15:0] d;
	} egh_row_t;

	logic                      ref_clk, rst_n, psel, penable, pwrite, pready, pslverr;
	logic [7:0]                paddr;
	logic [31:0]               pwdata, prdata, r;
	logic                      cmd_valid, trig_in, motion_stopped, e, bad, seen, pol;
	logic signed [15:0]        cmd_delta;
	logic                      enc_valid, prof_dir, pos_zero, mt_clear, speed_unit, irq;
	logic signed [31:0]        enc_delta;
	logic [VEL_W-1:0]          prof_vel;
	logic [ACC_W-1:0]          prof_rate;
	int                        bad_count, samples_checked;
	longint                    n, dd, acc, q, rem;
	// ratios kept inside the guaranteed range except the overflow rows
	egh_row_t rows [9] = '{
		'{1'b1, 32'd10000, 32'd1, 32'd1, 16'sd10000},
		'{1'b1, 32'd3, 32'd1, 32'd1, 16'sd1},
		'{1'b0, 32'd3, 32'd1, 32'd1, 16'sd1},
		'{1'b0, 32'd3, 32'd1, 32'd1, 16'sd1},
		'{1'b1, 32'd0, 32'd9568256, 32'd3375, 16'sd3375},
		'{1'b1, 32'd0, 32'hffff_ffff, 32'd1, 16'sh7fff},
		'{1'b1, 32'd0, 32'd1, 32'd0, 16'sd1},
		'{1'b1, 32'd0, 32'd1, 32'd1000, -16'sd1},
		'{1'b0, 32'd0, 32'd1, 32'd1000, -16'sd999}
	};
	logic [7:0]  ra [5] = '{OFS_PPR, OFS_NUM, OFS_DEN, OFS_ACC, 8'h40};
	logic [31:0] rv [5] = '{32'h0, NUM_RST, DEN_RST, ACC_MIN, 32'h0};

	egh_host egh_host_i (.ref_clk(ref_clk), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	egh_top egh_top_i (.ref_clk(ref_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cmd_valid(cmd_valid), .cmd_delta(cmd_delta),
		.trig_in(trig_in), .motion_stopped(motion_stopped), .enc_valid(enc_valid),
		.enc_delta(enc_delta), .prof_vel(prof_vel), .prof_rate(prof_rate),
		.prof_dir(prof_dir), .pos_zero(pos_zero), .mt_clear(mt_clear),
		.speed_unit(speed_unit), .irq(irq));

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		samples_checked++;
		if (got !== ex) begin
			$display("unexpected %s expected %h seen %h", nm, ex, got);
			bad_count++;
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic give_up();
		$display("unexpected wait expected done seen timeout");
		bad_count++;
		end_of_test();
	endtask

	task automatic pulse(input logic signed [15:0] d);
		@(posedge ref_clk);
		cmd_valid <= 1'b1;
		cmd_delta <= d;
		@(posedge ref_clk);
		cmd_valid <= 1'b0;
		#1;
	endtask

	task automatic wait_vel(input logic [30:0] v);
		int k;
		k = 0;
		do begin
			@(posedge ref_clk);
			#1;
			k++;
		end while (prof_vel !== v && k < 50);
		if (prof_vel !== v) give_up();
		@(posedge ref_clk);
	endtask

	initial begin
		bad_count = 0;
		samples_checked = 0;
		rst_n = 1'b0;
		cmd_valid = 1'b0;
		cmd_delta = 16'sh0;
		trig_in = 1'b0;
		motion_stopped = 1'b0;
		rem = 0;
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'b1;
		egh_host_i.wr(OFS_IMASK, 32'h7);
		for (int i = 0; i < 9; i++) begin
			if (rows[i].cfg) begin
				egh_host_i.wr(OFS_PPR, rows[i].ppr);
				egh_host_i.wr(OFS_NUM, rows[i].num);
				egh_host_i.wr(OFS_DEN, rows[i].den);
			end
			n = rows[i].ppr != 0 ? longint'(ENC_RES) : longint'(rows[i].num);
			dd = rows[i].ppr != 0 ? longint'(rows[i].ppr) : longint'(rows[i].den);
			acc = longint'(rows[i].d) * n + rem;
			q = dd != 0 ? acc / dd : 0;
			bad = dd == 0 || q > 64'sd2147483647 || q < -64'sd2147483647;
			pulse(rows[i].d);
			chk("enc valid", !bad, enc_valid);
			if (!bad) begin
				chk("enc delta", q[31:0], enc_delta);
				rem = acc - q * dd;
			end else begin
				egh_host_i.rd(OFS_IST, r, e);
				chk("alarm", 32'h1, r);
				chk("irq set", 1'b1, irq);
				egh_host_i.wr(OFS_IST, 32'h1);
			end
		end
		// reset-like values after a register reset read-back
		rst_n <= 1'b0;
		@(posedge ref_clk);
		rst_n <= 1'b1;
		#1;
		chk("rate reset", 32'h1, prof_rate);
		chk("irq reset", 1'b0, irq);
		for (int k = 0; k < 5; k++) begin
			egh_host_i.rd(ra[k], r, e);
			chk("reg reset", rv[k], r);
			chk("slverr", k == 4, e);
		end
		// masked alarm keeps irq low
		egh_host_i.wr(OFS_DEN, 32'h0);
		pulse(16'sd1);
		egh_host_i.rd(OFS_IST, r, e);
		chk("masked alarm", 32'h1, r);
		chk("irq masked", 1'b0, irq);
		egh_host_i.wr(OFS_IST, 32'h1);
		egh_host_i.rd(OFS_IST, r, e);
		chk("alarm clear", 32'h0, r);
		egh_host_i.wr(OFS_ACC, 32'h0);
		egh_host_i.rd(OFS_ACC, r, e);
		chk("acc low clamp", ACC_MIN, r);
		egh_host_i.wr(OFS_ACC, 32'h0007_0000);
		egh_host_i.rd(OFS_ACC, r, e);
		chk("acc high clamp", ACC_MAX, r);
		egh_host_i.wr(OFS_VFAST, 32'hffff_ffff);
		egh_host_i.rd(OFS_VFAST, r, e);
		chk("vfast width", 32'h7fff_ffff, r);
		egh_host_i.wr(OFS_IMASK, 32'h7);
		// cyclic position, cyclic velocity and cyclic torque all refuse profile homing
		for (int m = 0; m < 4; m++) begin
			if (m == 1) continue;
			egh_host_i.wr(OFS_CTRL, 32'h4 | m);
			@(posedge ref_clk);
			#1;
			chk("speed unit", 1'b1, speed_unit);
			egh_host_i.home(TYPE_HOME_Z, 1'b0);
			egh_host_i.rd(OFS_IST, r, e);
			chk("refused", 32'h4, r);
			egh_host_i.wr(OFS_IST, 32'h7);
		end
		seen = 1'b0;
		fork
			egh_host_i.wr(OFS_CMD, {16'h0, TYPE_MT_CLR, CMD_HOME});
			repeat (8) begin
				@(posedge ref_clk);
				#1;
				if (mt_clear === 1'b1) seen = 1'b1;
			end
		join
		chk("mt clear", 1'b1, seen);
		egh_host_i.wr(OFS_ACC, 32'd100);
		egh_host_i.wr(OFS_DEC, 32'd200);
		egh_host_i.wr(OFS_VSLOW, 32'd5);
		for (int t = 0; t < 2; t++) begin
			pol = t[0];
			@(posedge ref_clk);
			trig_in <= pol;
			motion_stopped <= 1'b0;
			egh_host_i.wr(OFS_CTRL, {28'h0, pol, 3'b001});
			egh_host_i.home(t == 0 ? TYPE_HOME_Z : TYPE_HOME_H, 1'b1);
			wait_vel(31'h7fff_ffff);
			chk("fast rate", 32'd100, prof_rate);
			chk("direction", pol, prof_dir);
			trig_in <= !pol;
			wait_vel(31'h0);
			chk("brake rate", 32'd200, prof_rate);
			motion_stopped <= 1'b1;
			wait_vel(31'd5);
			chk("slow rate", 32'd100, prof_rate);
			motion_stopped <= 1'b0;
			trig_in <= pol;
			@(posedge ref_clk);
			trig_in <= !pol;
			wait_vel(31'h0);
			chk("stop rate", 32'd200, prof_rate);
			motion_stopped <= 1'b1;
			seen = 1'b0;
			repeat (20) begin
				@(posedge ref_clk);
				#1;
				if (pos_zero === 1'b1) seen = 1'b1;
			end
			chk("zeroed", 1'b1, seen);
			egh_host_i.rd(OFS_STAT, r, e);
			chk("done set", 2'b10, r[ST_DONE:ST_INPROG]);
			egh_host_i.rd(OFS_IST, r, e);
			chk("homed event", 32'h2, r);
			chk("irq homed", 1'b1, irq);
			egh_host_i.wr(OFS_IST, 32'h2);
		end
		end_of_test();
	end
endmodule
